// >>> hdl/pcrc_pkg.sv
/*
  Constants and types shared by the programmable CRC generator: register
  byte offsets, alias codes, control field positions, FIFO capacities.
  Assumes a 12-bit APB byte address space inside the peripheral slot.
*/
package pcrc_pkg;

  // Address space and register byte offsets
  localparam int unsigned ADDR_W     = 12;
  localparam logic [11:0] OFF_DATA   = 12'h420;
  localparam logic [11:0] OFF_RESULT = 12'h430;
  localparam logic [11:0] OFF_CTRL   = 12'ha00;
  localparam logic [11:0] OFF_TAPS   = 12'ha10;
  localparam logic [11:0] OFF_STAT   = 12'ha20;
  localparam logic [11:0] OFF_MASK   = 12'ha30;

  // Alias selector taken from address bits 3:2
  localparam logic [1:0] ALIAS_BASE = 2'h0;
  localparam logic [1:0] ALIAS_CLR  = 2'h1;
  localparam logic [1:0] ALIAS_SET  = 2'h2;
  localparam logic [1:0] ALIAS_INV  = 2'h3;

  // Control register fields
  localparam int unsigned CTL_DW_LSB = 24;
  localparam int unsigned CTL_PL_LSB = 16;
  localparam int unsigned CTL_ON     = 15;
  localparam int unsigned CTL_VW_LSB = 8;
  localparam int unsigned CTL_FUL    = 7;
  localparam int unsigned CTL_MPT    = 6;
  localparam int unsigned CTL_ISEL   = 5;
  localparam int unsigned CTL_GO     = 4;
  localparam int unsigned CTL_LEND   = 3;
  localparam logic [31:0] CTL_WMASK  = 32'h1f1f_a03c;
  localparam logic [31:0] TAPS_WMASK = 32'hffff_fffe;
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;

  // FIFO capacity versus data width field
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [4:0]  DW_8MAX    = 5'h07;
  localparam logic [4:0]  DW_16MAX   = 5'h0f;
  localparam logic [4:0]  CAP_8      = 5'h10;
  localparam logic [4:0]  CAP_16     = 5'h08;
  localparam logic [4:0]  CAP_32     = 5'h04;

  // Interrupt status bits
  localparam int unsigned STAT_W    = 2;
  localparam int unsigned STAT_DONE = 0;
  localparam int unsigned STAT_OVF  = 1;

  typedef enum logic {SH_IDLE, SH_RUN} pcrc_sh_t;

endpackage : pcrc_pkg

// >>> hdl/pcrc_shifter.sv
/*
  Serial CRC shifter: takes one data word, feeds it one bit per enabled
  clock into the running CRC and offers the updated value each step.
  Assumes the owner holds the CRC register and writes back crc_step.
*/
`timescale 1ns/1ps
module pcrc_shifter
  import pcrc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // Word handoff
  input  wire logic        load,
  input  wire logic [31:0] word,
  input  wire logic        abort,
  // Configuration
  input  wire logic [4:0]  data_width_field,
  input  wire logic [4:0]  poly_length_field,
  input  wire logic        shift_direction_bit,
  input  wire logic [31:0] taps,
  // Running CRC
  input  wire logic [31:0] crc_cur,
  output logic [31:0]      crc_step,
  output logic             step,
  output logic             busy
);

  pcrc_sh_t    state_r, state_nxt;
  logic [31:0] word_r, word_nxt;
  logic [4:0]  cnt_r, cnt_nxt;
  logic [4:0]  dw_r, dw_nxt;
  logic        lend_r, lend_nxt;
  logic        in_bit;
  logic        fb;

  // Bit order picked per word at load time
  assign in_bit = lend_r ? word_r[cnt_r] : word_r[dw_r - cnt_r]; // R2
  assign fb     = crc_cur[poly_length_field] ^ in_bit;
  assign busy   = (state_r == SH_RUN);
  assign step   = busy & ~abort;

  // Feedback into enabled taps, bits above the length held at zero
  assign crc_step[0] = fb; // R9
  for (genvar i = 1; i < 32; i++) begin : g_tap
    assign crc_step[i] = (5'(i) <= poly_length_field) & (crc_cur[i-1] ^ (fb & taps[i])); // R1 R9
  end

  // Sequencing: one bit per enabled cycle, abort drops the word
  always_comb begin
    state_nxt = state_r;
    word_nxt  = word_r;
    cnt_nxt   = cnt_r;
    dw_nxt    = dw_r;
    lend_nxt  = lend_r;
    unique case (state_r)
      SH_IDLE: begin
        if (load && !abort) begin
          state_nxt = SH_RUN;
          word_nxt  = word;
          cnt_nxt   = '0;
          dw_nxt    = data_width_field; // R3
          lend_nxt  = shift_direction_bit;
        end
      end
      SH_RUN: begin
        if (abort || cnt_r == dw_r) begin // R6
          state_nxt = SH_IDLE;
          cnt_nxt   = '0;
        end else begin
          cnt_nxt = cnt_r + 5'h01;
        end
      end
    endcase
  end

  // Register stage, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SH_IDLE;
      word_r  <= RST_ZERO;
      cnt_r   <= '0;
      dw_r    <= '0;
      lend_r  <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      word_r  <= word_nxt;
      cnt_r   <= cnt_nxt;
      dw_r    <= dw_nxt;
      lend_r  <= lend_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_lsb_first;
    (ce && state_r == SH_IDLE && load && !abort && shift_direction_bit) |=> (in_bit == $past(word[0]));
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("first bit not lsb"); // R2

  property p_msb_first;
    (ce && state_r == SH_IDLE && load && !abort && !shift_direction_bit) |=> (in_bit == $past(word[data_width_field]));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit not msb"); // R2

  property p_word_len;
    (ce && busy && !abort && cnt_r == dw_r) |=> (!busy && cnt_r == 5'h00);
  endproperty
  a_word_len: assert property (p_word_len) else $error("word length wrong"); // R5

  c_lend: cover property (ce && step && lend_r && cnt_r == dw_r);

endmodule : pcrc_shifter

// >>> hdl/pcrc_top.sv
/*
  Programmable CRC generator with APB register slave, 16-entry data FIFO,
  set/clear/invert write aliases and a masked level interrupt.
  Assumes an APB master on pclk; ce low freezes every flip-flop.
*/
// Decided for this implementation: the APB interface to the registers.
// Notes on behaviour
// (R1) Software polynomial up to 32 bits
// (R2) Software picks LSB-first or MSB-first shifting
// (R3) Data width and polynomial length independent
// (R4) Clear, set, invert aliases at +4/+8/+C
// (R5) Width and length fields hold value minus one
// (R6) Start bit runs shifter; clearing aborts
// (R7) Interrupt on FIFO empty or shift done
// (R8) FIFO capacity 16/8/4 by data width
// (R9) Taps feedback within length; result readable
`timescale 1ns/1ps
module pcrc_top
  import pcrc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  // APB slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Interrupt
  output logic                   irq
);

  logic [31:0]       ctl_r, ctl_nxt;
  logic [31:0]       taps_r, taps_nxt;
  logic [31:0]       result_r, result_nxt;
  logic [31:0]       last_r, last_nxt;
  logic [STAT_W-1:0] mask_r, mask_nxt;
  logic [STAT_W-1:0] stat_r, stat_nxt;
  logic [31:0]       prdata_r, prdata_nxt;
  logic              pready_r, pready_nxt;
  logic              pslverr_r, pslverr_nxt;
  logic              irq_r, irq_nxt;
  logic              pend_r, pend_nxt;
  logic [31:0]       mem [FIFO_DEPTH];
  logic [3:0]        wp_r, wp_nxt, rp_r, rp_nxt;
  logic [4:0]        cnt_r, cnt_nxt;

  logic [11:0]       base;
  logic [1:0]        op;
  logic              hit_data, hit_res, hit_ctl, hit_taps, hit_stat, hit_mask, mapped;
  logic              wr_fire, rd_fire;
  logic [4:0]        dw, pl, cap;
  logic              on, go, isel, full, empty;
  logic              push, pop, ovf, evt, abort;
  logic [31:0]       ctl_rd, data_in;
  logic              sh_busy, sh_step;
  logic [31:0]       crc_step;

  // Alias operation against the current base value
  function automatic logic [31:0] pcrc_alias(input logic [1:0] sel,
                                             input logic [31:0] cur,
                                             input logic [31:0] wd);
    logic [31:0] v;
    v = wd;
    unique case (sel)
      ALIAS_BASE: v = wd;
      ALIAS_CLR:  v = cur & ~wd;
      ALIAS_SET:  v = cur | wd;
      ALIAS_INV:  v = cur ^ wd;
    endcase
    return v;
  endfunction : pcrc_alias

  // Address decode; aliases share the base register's 16-byte slot
  assign base     = {paddr[11:4], 4'h0};
  assign op       = paddr[3:2]; // R4
  assign hit_data = (base == OFF_DATA);
  assign hit_res  = (base == OFF_RESULT);
  assign hit_ctl  = (base == OFF_CTRL);
  assign hit_taps = (base == OFF_TAPS);
  assign hit_stat = (base == OFF_STAT);
  assign hit_mask = (base == OFF_MASK);
  assign mapped   = (paddr[1:0] == 2'h0) &
                    (hit_data | hit_res | hit_ctl | hit_taps | hit_stat | hit_mask);
  assign wr_fire  = psel & penable & pready_r & pwrite & mapped;
  assign rd_fire  = psel & penable & pready_r & ~pwrite & mapped;

  // Control fields and FIFO capacity
  assign dw    = ctl_r[CTL_DW_LSB +: 5]; // R5
  assign pl    = ctl_r[CTL_PL_LSB +: 5]; // R5
  assign on    = ctl_r[CTL_ON];
  assign go    = ctl_r[CTL_GO];
  assign isel  = ctl_r[CTL_ISEL];
  assign cap   = (dw <= DW_8MAX) ? CAP_8 : (dw <= DW_16MAX) ? CAP_16 : CAP_32; // R8
  assign full  = (cnt_r >= cap); // R8
  assign empty = (cnt_r == 5'h00); // R8
  assign ctl_rd = (ctl_r & CTL_WMASK) | (32'(cnt_r) << CTL_VW_LSB) |
                  (32'(full) << CTL_FUL) | (32'(empty) << CTL_MPT);

  // FIFO traffic; a write into a full FIFO is dropped and flagged
  assign data_in = pcrc_alias(op, last_r, pwdata);
  assign push    = wr_fire & hit_data & ~full;
  assign ovf     = wr_fire & hit_data & full;
  assign abort   = ~(on & go); // R6
  assign pop     = ~abort & ~sh_busy & ~empty; // R6

  // Completion event: isel picks FIFO-empty or shift-finished
  assign evt = pend_r & on & go & empty & (isel | ~sh_busy); // R7

  pcrc_shifter u_shifter (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .load     (pop),
    .word     (mem[rp_r]),
    .abort    (abort),
    .data_width_field   (dw),
    .poly_length_field     (pl),
    .shift_direction_bit  (ctl_r[CTL_LEND]),
    .taps     (taps_r),
    .crc_cur  (result_r),
    .crc_step (crc_step),
    .step     (sh_step),
    .busy     (sh_busy)
  );

  // Register file, bus answers and interrupt next values
  always_comb begin
    ctl_nxt     = ctl_r;
    taps_nxt    = taps_r;
    result_nxt  = sh_step ? crc_step : result_r; // R9
    last_nxt    = push ? data_in : last_r;
    mask_nxt    = mask_r;
    pend_nxt    = abort ? 1'b0 : ((pend_r & ~evt) | pop);
    stat_nxt    = stat_r;
    prdata_nxt  = RST_ZERO;
    pready_nxt  = psel & ~penable;
    pslverr_nxt = psel & ~penable & ~mapped;
    if (wr_fire && hit_ctl)
      ctl_nxt = pcrc_alias(op, ctl_r, pwdata) & CTL_WMASK; // R4 R3
    if (wr_fire && hit_taps)
      taps_nxt = pcrc_alias(op, taps_r, pwdata) & TAPS_WMASK; // R4 R1
    if (wr_fire && hit_res)
      result_nxt = pcrc_alias(op, result_r, pwdata); // R4
    if (wr_fire && hit_mask)
      mask_nxt = STAT_W'(pcrc_alias(op, 32'(mask_r), pwdata)); // R4
    // Read clears only the bits it returned; a new event wins
    if (rd_fire && hit_stat)
      stat_nxt = stat_r & ~prdata_r[STAT_W-1:0];
    if (evt)
      stat_nxt[STAT_DONE] = 1'b1; // R7
    if (ovf)
      stat_nxt[STAT_OVF] = 1'b1;
    if (psel && !penable && !pwrite && mapped) begin
      unique case (1'b1)
        hit_data: prdata_nxt = last_r;
        hit_res:  prdata_nxt = result_r; // R9
        hit_ctl:  prdata_nxt = ctl_rd;
        hit_taps: prdata_nxt = taps_r;
        hit_stat: prdata_nxt = 32'(stat_r);
        hit_mask: prdata_nxt = 32'(mask_r);
      endcase
    end
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  // FIFO pointers and word count
  always_comb begin
    wp_nxt  = push ? wp_r + 4'h1 : wp_r;
    rp_nxt  = pop ? rp_r + 4'h1 : rp_r;
    cnt_nxt = cnt_r + 5'(push) - 5'(pop); // R8
  end

  // Control and bus state; nothing moves while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r     <= RST_ZERO;
      taps_r    <= RST_ZERO;
      result_r  <= RST_ZERO;
      last_r    <= RST_ZERO;
      mask_r    <= '0;
      stat_r    <= '0;
      prdata_r  <= RST_ZERO;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r     <= 1'b0;
      pend_r    <= 1'b0;
      wp_r      <= '0;
      rp_r      <= '0;
      cnt_r     <= '0;
    end else if (ce) begin
      ctl_r     <= ctl_nxt;
      taps_r    <= taps_nxt;
      result_r  <= result_nxt;
      last_r    <= last_nxt;
      mask_r    <= mask_nxt;
      stat_r    <= stat_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r     <= irq_nxt;
      pend_r    <= pend_nxt;
      wp_r      <= wp_nxt;
      rp_r      <= rp_nxt;
      cnt_r     <= cnt_nxt;
    end
  end

  // Data storage needs no reset; count guards stale entries
  always_ff @(posedge pclk) begin
    if (ce && push)
      mem[wp_r] <= data_in;
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_taps_write;
    (ce && wr_fire && hit_taps && op == ALIAS_BASE) |=> (taps_r == ($past(pwdata) & TAPS_WMASK));
  endproperty
  a_taps_write: assert property (p_taps_write) else $error("taps not loaded"); // R1

  property p_width_indep;
    (ce && wr_fire && hit_ctl && op == ALIAS_BASE) |=>
      (dw == $past(pwdata[CTL_DW_LSB +: 5]) && pl == $past(pwdata[CTL_PL_LSB +: 5]));
  endproperty
  a_width_indep: assert property (p_width_indep) else $error("fields not independent"); // R3

  property p_alias_set;
    (ce && wr_fire && hit_ctl && op == ALIAS_SET) |=>
      (ctl_r == (($past(ctl_r) | $past(pwdata)) & CTL_WMASK));
  endproperty
  a_alias_set: assert property (p_alias_set) else $error("set alias wrong"); // R4

  property p_alias_clr;
    (ce && wr_fire && hit_taps && op == ALIAS_CLR) |=>
      (taps_r == ($past(taps_r) & ~$past(pwdata)));
  endproperty
  a_alias_clr: assert property (p_alias_clr) else $error("clear alias wrong"); // R4

  property p_abort;
    (ce && !go && sh_busy && !(wr_fire && hit_res)) |=>
      (!sh_busy && result_r == $past(result_r));
  endproperty
  a_abort: assert property (p_abort) else $error("abort not honoured"); // R6

  property p_irq_cause;
    $rose(stat_r[STAT_DONE]) |->
      ($past(empty) && ($past(isel) || !$past(sh_busy)));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("done set early"); // R7

  property p_fifo_cap;
    (ce && cnt_r >= cap) |=> (cnt_r <= $past(cnt_r));
  endproperty
  a_fifo_cap: assert property (p_fifo_cap) else $error("fifo over capacity"); // R8

  property p_len_mask;
    (ce && sh_step && !wr_fire) |=> ((result_r >> pl) <= 32'h0000_0001);
  endproperty
  a_len_mask: assert property (p_len_mask) else $error("result above length"); // R9

  c_full:  cover property (ce && full && push == 1'b0 && cnt_r == CAP_32);
  c_done:  cover property (ce && evt && !isel);
  c_early: cover property (ce && evt && isel && sh_busy);
  c_irq:   cover property (irq_r);

endmodule : pcrc_top

// >>> testbench/pcrc_bench.sv
/*
  Self-checking bench for the programmable CRC generator: reset values,
  unmapped access, write aliases, FIFO capacity, CRC results, interrupt.
  Assumes pcrc_pkg and pcrc_top are compiled first; drives APB directly.
*/
`timescale 1ns/1ps
module pcrc_bench;
  import pcrc_pkg::*;

  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r1, tp, sd, w, cfg;
  logic [4:0]  dw, pl;
  logic        le, isel, err;
  int          seed, k, i, n, cap, miscompares, checks_done;

  pcrc_top i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));

  always #12.5 pclk = ~pclk;

  // Reference CRC, one bit per step, bits above length cleared
  function automatic logic [31:0] crc_model(logic [31:0] c, logic [31:0] t,
                                            logic [31:0] d, int wd, int ln, logic lf);
    logic [31:0] nx;
    logic        fb;
    for (int b = 0; b <= wd; b++) begin
      fb = c[ln] ^ (lf ? d[b] : d[wd-b]);
      nx = 32'h0;
      nx[0] = fb;
      for (int j = 1; j <= ln; j++) nx[j] = c[j-1] ^ (fb & t[j]);
      c = nx;
    end
    return c;
  endfunction : crc_model

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; request held until the rising edge that sees pready high
  task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= is_wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && t < 20) begin
      @(posedge pclk);
      t++;
    end
    if (t >= 20) begin
      miscompares++;
      end_of_test();
    end
    // Answer taken at the same edge, only then released
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask : rchk

  // Run the shifter until the FIFO is empty, then stop and clear status
  task automatic drain();
    wr(OFF_CTRL + 12'h8, 32'h0000_8010);
    n = 0;
    rd = 32'h0;
    while (rd[6] !== 1'b1 && n < 200) begin
      apb(1'b0, OFF_CTRL, 32'h0);
      n++;
    end
    chk("drain empty", 32'h1, {31'h0, rd[6]});
    wr(OFF_CTRL + 12'h4, 32'h0000_8010);
    apb(1'b0, OFF_STAT, 32'h0);
  endtask : drain

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // Watchdog: far above the expected run length
  initial begin
    repeat (80000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end

  initial begin
    seed = 85; pclk = 1'b0; presetn = 1'b0; ce = 1'b1; paddr = 12'h0; psel = 1'b0;
    penable = 1'b0; pwrite = 1'b0; pwdata = 32'h0; miscompares = 0; checks_done = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values and refused addresses
    rchk(OFF_CTRL, 32'h0000_0040);
    rchk(OFF_TAPS, RST_ZERO);
    rchk(OFF_RESULT, RST_ZERO);
    rchk(OFF_DATA, RST_ZERO);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b0, 12'ha02, 32'h0);
    chk("misaligned err", 32'h1, {31'h0, err});
    $display("test reset done");
    // Clear, set, invert aliases; bit 0 of taps never holds
    wr(OFF_TAPS, 32'hf0f0_f0f0);
    wr(OFF_TAPS + 12'h4, 32'h3000_0000);
    wr(OFF_TAPS + 12'h8, 32'h0000_000f);
    wr(OFF_TAPS + 12'hc, 32'hff00_0000);
    rchk(OFF_TAPS, (((32'hf0f0_f0f0 & ~32'h3000_0000) | 32'hf) ^ 32'hff00_0000) & 32'hffff_fffe);
    wr(OFF_MASK + 12'h8, 32'h1);
    rchk(OFF_MASK, 32'h1);
    $display("test alias done");
    // FIFO capacity per width band, then one push too many
    for (k = 0; k < 3; k++) begin
      dw = (k == 0) ? 5'h07 : (k == 1) ? 5'h0f : 5'h1f;
      cap = 16 >> k;
      wr(OFF_CTRL, {3'h0, dw, 24'h0});
      for (i = 0; i <= cap; i++) wr(OFF_DATA, $random(seed));
      rchk(OFF_CTRL, {3'h0, dw, 11'h0, cap[4:0], 8'h80});
      chk("masked irq", 32'h0, {31'h0, irq});
      apb(1'b0, OFF_STAT, 32'h0);
      chk("overflow", 32'h2, rd & 32'h2);
      drain();
    end
    $display("test fifo done");
    // Random CRC runs with both directions and both interrupt modes
    for (k = 0; k < 8; k++) begin
      dw = 5'($random(seed));
      pl = 5'($random(seed));
      le = k[0];
      isel = k[1];
      if (k == 2) begin
        dw = 5'h1f; pl = 5'h1f;
      end
      if (k == 5) begin
        dw = 5'h00; pl = 5'h00;
      end
      tp = $random(seed) & 32'hffff_fffe; sd = $random(seed); w = $random(seed);
      cfg = {3'h0, dw, 3'h0, pl, 10'h0, isel, 1'b0, le, 3'h0};
      wr(OFF_CTRL, cfg);
      wr(OFF_TAPS, tp);
      wr(OFF_RESULT, sd);
      wr(OFF_DATA, w);
      apb(1'b0, OFF_STAT, 32'h0);
      wr(OFF_CTRL + 12'h8, 32'h0000_8010);
      n = 0;
      while (irq !== 1'b1 && n < 100) begin
        @(negedge pclk);
        n++;
      end
      chk("irq raised", 32'h1, {31'h0, irq});
      if (isel) chk("early irq", 32'h1, {31'h0, n <= 6});
      else chk("late irq", 32'h1, {31'h0, n > int'(dw)});
      apb(1'b0, OFF_STAT, 32'h0);
      chk("done status", 32'h1, rd & 32'h3);
      chk("irq cleared", 32'h0, {31'h0, irq});
      repeat (40) @(posedge pclk);
      rchk(OFF_RESULT, crc_model(sd, tp, w, dw, pl, le));
      rchk(OFF_CTRL, cfg | 32'h0000_8050);
      wr(OFF_CTRL + 12'h4, 32'h0000_8010);
    end
    $display("test crc done");
    // Abort mid-word: second word stays queued, result frozen
    wr(OFF_CTRL, 32'h1f1f_0000);
    wr(OFF_DATA, $random(seed));
    wr(OFF_DATA, $random(seed));
    wr(OFF_CTRL + 12'h8, 32'h0000_8010);
    repeat (4) @(posedge pclk);
    wr(OFF_CTRL + 12'h4, 32'h0000_0010);
    rchk(OFF_CTRL, 32'h1f1f_8100);
    apb(1'b0, OFF_RESULT, 32'h0);
    r1 = rd;
    repeat (50) @(posedge pclk);
    rchk(OFF_RESULT, r1);
    $display("test abort done");
    end_of_test();
  end
endmodule : pcrc_bench
